// [core/bss_pkg.sv]
// Package of constants shared by the boot source selector files
package bss_pkg;

  // ----------------------------------------
  // Boot source codes (equal to the fuse field codes)
  // ----------------------------------------
  localparam logic [3:0] SRC_STRAP = 4'h0;
  localparam logic [3:0] SRC_SERIAL0 = 4'h1;
  localparam logic [3:0] SRC_QUAD = 4'h2;
  localparam logic [3:0] SRC_STATIC8 = 4'h3;
  localparam logic [3:0] SRC_STATIC16 = 4'h4;
  localparam logic [3:0] SRC_STATIC32 = 4'h5;
  localparam logic [3:0] SRC_USB_PORT_ZERO = 4'h6;
  localparam logic [3:0] SRC_USB_PORT_ONE = 4'h7;
  localparam logic [3:0] SRC_SYNC_SERIAL = 4'h8;
  localparam logic [3:0] SRC_SERIAL3 = 4'h9;
  localparam logic [3:0] SRC_INVALID = 4'hf;

  // ----------------------------------------
  // Static memory bus width codes
  // ----------------------------------------
  localparam logic [1:0] WIDTH_NONE = 2'h0;
  localparam logic [1:0] WIDTH_8 = 2'h1;
  localparam logic [1:0] WIDTH_16 = 2'h2;
  localparam logic [1:0] WIDTH_32 = 2'h3;

  // ----------------------------------------
  // Fuse store layout (32-bit word indices)
  // ----------------------------------------
  localparam int OTP_WORDS = 10;
  localparam logic [3:0] OTP_IDX_GENERAL = 4'h0;
  localparam logic [3:0] OTP_IDX_KEY0_FIRST = 4'h1;
  localparam logic [3:0] OTP_IDX_KEY1_LAST = 4'h8;
  localparam logic [3:0] OTP_IDX_BOOT_CFG = 4'h9;
  localparam int BOOT_FIELD_LSB = 0;
  localparam int BOOT_PROG_BIT = 31;
  localparam logic [31:0] OTP_RESET_VALUE = 32'h0000_0000;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;

  typedef enum {
    BSS_ST_START,
    BSS_ST_SETTLE,
    BSS_ST_FETCH,
    BSS_ST_WAIT,
    BSS_ST_DECIDE,
    BSS_ST_DONE
  } bss_state_t;

endpackage

// [core/bss_otp_if.sv]
// Interface between the selector core and its fuse store
`timescale 1ns/10ps
interface bss_otp_if;
  logic rd_en;
  logic [3:0] rd_addr;
  logic [31:0] rd_data;
  logic wr_en;
  logic [3:0] wr_addr;
  logic [31:0] wr_data;
  logic key_set;

  modport mem (
    input rd_en,
    input rd_addr,
    input wr_en,
    input wr_addr,
    input wr_data,
    output rd_data,
    output key_set
  );

  modport user (
    output rd_en,
    output rd_addr,
    output wr_en,
    output wr_addr,
    output wr_data,
    input rd_data,
    input key_set
  );
endinterface

// [core/bss_otp_mem.sv]
// One-time programmable fuse store: general word, two key blocks, boot word
`timescale 1ns/10ps
module bss_otp_mem #(
  parameter int WORDS = bss_pkg::OTP_WORDS
) (
  input wire logic clk_in,
  input wire logic rst_in,
  bss_otp_if.mem otp
);
  logic [31:0] mem_r [WORDS];
  logic [31:0] rd_data_r;
  logic key_set_r;

  // ----------------------------------------
  // Fuse array
  // ----------------------------------------
  // one general word, two 128-bit blocks, one boot word
  // Programming only sets bits; a blown fuse returns to zero only when rst_in clears the whole array
  genvar g;
  generate
    for (g = 0; g < WORDS; g++) begin : g_word
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          mem_r[g] <= bss_pkg::OTP_RESET_VALUE;
        end else if (otp.wr_en && otp.wr_addr == 4'(g)) begin
          mem_r[g] <= mem_r[g] | otp.wr_data;
        end
      end
    end
  endgenerate

  // Registered read port
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_data_r <= 32'h0000_0000;
    end else if (otp.rd_en && otp.rd_addr < 4'(WORDS)) begin
      rd_data_r <= mem_r[otp.rd_addr];
    end else if (otp.rd_en) begin
      rd_data_r <= 32'h0000_0000;
    end
  end

  // Sticky flag: any key bit ever programmed
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      key_set_r <= 1'b0;
    end else if (otp.wr_en && otp.wr_addr >= bss_pkg::OTP_IDX_KEY0_FIRST &&
                 otp.wr_addr <= bss_pkg::OTP_IDX_KEY1_LAST && otp.wr_data != 32'h0000_0000) begin
      key_set_r <= 1'b1;
    end
  end

  assign otp.rd_data = rd_data_r;
  assign otp.key_set = key_set_r;
endmodule

// [core/bss_decoder.sv]
// Boot source decoder for fuse field and strap pattern
`timescale 1ns/10ps
module bss_decoder (
  input wire logic [3:0] field_in,
  input wire logic programmed_in,
  input wire logic [3:0] strap_in,
  output logic [3:0] source_out,
  output logic [1:0] width_out,
  output logic fuse_used_out
);
  // Strap pattern, pin 3 down to pin 0, to a boot source code
  // strap pattern table
  function automatic logic [3:0] strap_code(input logic [3:0] p);
    case (p)
      4'h0: strap_code = bss_pkg::SRC_SERIAL0;
      4'h1: strap_code = bss_pkg::SRC_QUAD;
      4'h2: strap_code = bss_pkg::SRC_STATIC8;
      4'h3: strap_code = bss_pkg::SRC_STATIC16;
      4'h4: strap_code = bss_pkg::SRC_STATIC32;
      4'h5: strap_code = bss_pkg::SRC_USB_PORT_ZERO;
      4'h6: strap_code = bss_pkg::SRC_USB_PORT_ONE;
      4'h7: strap_code = bss_pkg::SRC_SYNC_SERIAL;
      4'h8: strap_code = bss_pkg::SRC_SERIAL3;
      default: strap_code = bss_pkg::SRC_INVALID;
    endcase
  endfunction

  // Static memory width belonging to a source code
  function automatic logic [1:0] width_of(input logic [3:0] s);
    case (s)
      bss_pkg::SRC_STATIC8: width_of = bss_pkg::WIDTH_8;
      bss_pkg::SRC_STATIC16: width_of = bss_pkg::WIDTH_16;
      bss_pkg::SRC_STATIC32: width_of = bss_pkg::WIDTH_32;
      default: width_of = bss_pkg::WIDTH_NONE;
    endcase
  endfunction

  // Fuse wins when programmed and nonzero, else straps decide
  always_comb begin
    fuse_used_out = programmed_in && field_in != bss_pkg::SRC_STRAP;
    if (fuse_used_out) begin
      // fuse code passes through
      // Fuse codes above the last listed one are reserved
      source_out = (field_in > bss_pkg::SRC_SERIAL3) ? bss_pkg::SRC_INVALID : field_in;
    end else begin
      source_out = strap_code(strap_in);
    end
    width_out = width_of(source_out);
  end
endmodule

// [core/bss_top.sv]
// Boot source selector: strap capture, fuse readout and boot path decision
//
// Operation
// - Unprogrammed or zero fuse field: straps sampled at reset choose the boot path.
// - Fuse codes 0001, 0010, 0110 to 1001 select serial 0, quad flash, USB 0/1, SPI flash, serial 3.
// - Fuse codes 0011, 0100, 0101 select static memory boot at 8, 16, 32 bits.
// - Straps all low serial 0, only pin 0 quad flash, only pin 3 serial 3.
// - Straps 0010, 0011, 0100 select static memory boot at 8, 16, 32 bits.
// - Straps 0101 USB 0, 0110 USB 1, 0111 SPI flash on sync serial port.
// - Pin functions for SPI flash or quad flash follow the selected boot source.
// - After any reset the processor runs from internal boot memory first.
// - Fuse store holds two 32-bit words and two 128-bit key blocks.
// - On decryption-capable parts, plain image boot only in development mode, which ends once a key exists.
// - Decryption-capable parts with a key programmed authenticate with CMAC and boot encrypted images.
`timescale 1ns/10ps
module bss_top #(
  parameter bit AES_CAPABLE = 1'b1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic warm_rst_in,
  input wire logic strap_pin_3_in,
  input wire logic strap_pin_2_in,
  input wire logic strap_pin_1_in,
  input wire logic strap_pin_0_in,
  input wire logic otp_wr_en_in,
  input wire logic [3:0] otp_wr_addr_in,
  input wire logic [31:0] otp_wr_data_in,
  input wire logic otp_rd_en_in,
  input wire logic [3:0] otp_rd_addr_in,
  output logic [31:0] otp_rd_data_out,
  output logic otp_rd_valid_out,
  output logic [3:0] boot_source_out,
  output logic [1:0] static_width_out,
  output logic boot_from_fuse_out,
  output logic boot_invalid_out,
  output logic boot_ready_out,
  output logic rom_exec_out,
  output logic pinfunc_sync_serial_out,
  output logic pinfunc_quad_out,
  output logic dev_mode_out,
  output logic plain_boot_allowed_out,
  output logic cmac_auth_out,
  output logic encrypted_boot_out
);
  bss_otp_if otp ();

  bss_pkg::bss_state_t state_r;
  logic any_rst;
  logic [3:0] strap_meta_r;
  logic [3:0] strap_sync_r;
  logic [3:0] strap_cap_r;
  logic [1:0] settle_r;
  logic [3:0] field_r;
  logic prog_r;
  logic ext_rd_pend_r;
  logic [3:0] dec_source;
  logic [1:0] dec_width;
  logic dec_fuse_used;
  logic [3:0] boot_source_r;
  logic [1:0] static_width_r;
  logic fuse_used_r;
  logic invalid_r;
  logic ready_r;
  logic rom_exec_r;
  logic pf_ssp_r;
  logic pf_quad_r;
  logic dev_mode_r;
  logic plain_ok_r;
  logic cmac_r;
  logic encrypted_r;
  logic [31:0] rd_data_r;
  logic rd_valid_r;

  assign any_rst = rst_in | warm_rst_in;

  // ----------------------------------------
  // Strap pin synchroniser
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      strap_meta_r <= 4'h0;
      strap_sync_r <= 4'h0;
    end else begin
      strap_meta_r <= {strap_pin_3_in, strap_pin_2_in, strap_pin_1_in, strap_pin_0_in};
      strap_sync_r <= strap_meta_r;
    end
  end

  // ----------------------------------------
  // Selection sequencer
  // ----------------------------------------
  // one pass per reset, then hold
  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      state_r <= bss_pkg::BSS_ST_START;
    end else begin
      case (state_r)
        bss_pkg::BSS_ST_START: state_r <= bss_pkg::BSS_ST_SETTLE;
        bss_pkg::BSS_ST_SETTLE: begin
          if (settle_r == bss_pkg::STRAP_SETTLE_CYCLES) begin
            state_r <= bss_pkg::BSS_ST_FETCH;
          end
        end
        bss_pkg::BSS_ST_FETCH: state_r <= bss_pkg::BSS_ST_WAIT;
        bss_pkg::BSS_ST_WAIT: state_r <= bss_pkg::BSS_ST_DECIDE;
        bss_pkg::BSS_ST_DECIDE: state_r <= bss_pkg::BSS_ST_DONE;
        bss_pkg::BSS_ST_DONE: state_r <= bss_pkg::BSS_ST_DONE;
        default: state_r <= bss_pkg::BSS_ST_START;
      endcase
    end
  end

  // Wait for fresh pin levels to reach the synchroniser output
  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      settle_r <= 2'h0;
    end else if (state_r == bss_pkg::BSS_ST_SETTLE) begin
      settle_r <= settle_r + 2'h1;
    end
  end

  // strap levels latched once, after reset release
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      strap_cap_r <= 4'h0;
    end else if (state_r == bss_pkg::BSS_ST_FETCH) begin
      strap_cap_r <= strap_sync_r;
    end
  end

  // Fuse boot word latched when its read data returns
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      field_r <= 4'h0;
      prog_r <= 1'b0;
    end else if (state_r == bss_pkg::BSS_ST_WAIT) begin
      field_r <= otp.rd_data[bss_pkg::BOOT_FIELD_LSB +: 4];
      prog_r <= otp.rd_data[bss_pkg::BOOT_PROG_BIT];
    end
  end

  // ----------------------------------------
  // Fuse store port
  // ----------------------------------------
  // Sequencer owns the read port while fetching; outside reads are dropped then
  assign otp.rd_en = (state_r == bss_pkg::BSS_ST_FETCH) || otp_rd_en_in;
  assign otp.rd_addr = (state_r == bss_pkg::BSS_ST_FETCH) ? bss_pkg::OTP_IDX_BOOT_CFG
                                                          : otp_rd_addr_in;
  assign otp.wr_en = otp_wr_en_in;
  assign otp.wr_addr = otp_wr_addr_in;
  assign otp.wr_data = otp_wr_data_in;

  bss_otp_mem #(
    .WORDS(bss_pkg::OTP_WORDS)
  ) u_otp (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .otp(otp)
  );

  // Outside read answered two cycles after the request
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ext_rd_pend_r <= 1'b0;
      rd_valid_r <= 1'b0;
      rd_data_r <= 32'h0000_0000;
    end else begin
      ext_rd_pend_r <= otp_rd_en_in && state_r != bss_pkg::BSS_ST_FETCH;
      rd_valid_r <= ext_rd_pend_r;
      if (ext_rd_pend_r) begin
        rd_data_r <= otp.rd_data;
      end
    end
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  bss_decoder u_dec (
    .field_in(field_r),
    .programmed_in(prog_r),
    .strap_in(strap_cap_r),
    .source_out(dec_source),
    .width_out(dec_width),
    .fuse_used_out(dec_fuse_used)
  );

  // fuse or strap result registered once per reset
  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      boot_source_r <= bss_pkg::SRC_INVALID;
      static_width_r <= bss_pkg::WIDTH_NONE;
      fuse_used_r <= 1'b0;
      invalid_r <= 1'b0;
    end else if (state_r == bss_pkg::BSS_ST_DECIDE) begin
      boot_source_r <= dec_source;
      static_width_r <= dec_width;
      fuse_used_r <= dec_fuse_used;
      invalid_r <= dec_source == bss_pkg::SRC_INVALID;
    end
  end

  // processor runs from boot memory; ready marks the decision
  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      rom_exec_r <= 1'b1;
      ready_r <= 1'b0;
    end else begin
      rom_exec_r <= 1'b1;
      ready_r <= state_r == bss_pkg::BSS_ST_DECIDE || ready_r;
    end
  end

  // pin functions for the selected flash path
  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      pf_ssp_r <= 1'b0;
      pf_quad_r <= 1'b0;
    end else if (state_r == bss_pkg::BSS_ST_DECIDE) begin
      pf_ssp_r <= dec_source == bss_pkg::SRC_SYNC_SERIAL;
      pf_quad_r <= dec_source == bss_pkg::SRC_QUAD;
    end
  end

  // development mode lasts until a key is programmed
  // CMAC check and encrypted boot once a key exists
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dev_mode_r <= 1'b1;
      plain_ok_r <= 1'b1;
      cmac_r <= 1'b0;
      encrypted_r <= 1'b0;
    end else begin
      dev_mode_r <= AES_CAPABLE && !otp.key_set;
      plain_ok_r <= !AES_CAPABLE || !otp.key_set;
      cmac_r <= AES_CAPABLE && otp.key_set;
      encrypted_r <= AES_CAPABLE && otp.key_set;
    end
  end

  assign otp_rd_data_out = rd_data_r;
  assign otp_rd_valid_out = rd_valid_r;
  assign boot_source_out = boot_source_r;
  assign static_width_out = static_width_r;
  assign boot_from_fuse_out = fuse_used_r;
  assign boot_invalid_out = invalid_r;
  assign boot_ready_out = ready_r;
  assign rom_exec_out = rom_exec_r;
  assign pinfunc_sync_serial_out = pf_ssp_r;
  assign pinfunc_quad_out = pf_quad_r;
  assign dev_mode_out = dev_mode_r;
  assign plain_boot_allowed_out = plain_ok_r;
  assign cmac_auth_out = cmac_r;
  assign encrypted_boot_out = encrypted_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (any_rst);

  logic ready_d_r;
  logic rdy_rise;

  // Ready delayed by one clock, to find the decision edge
  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      ready_d_r <= 1'b0;
    end else begin
      ready_d_r <= ready_r;
    end
  end

  assign rdy_rise = ready_r && !ready_d_r;

  chk_strap_when_blank: assert property (
    rdy_rise && !(prog_r && field_r != 4'h0) |-> !fuse_used_r
  ) else $error("strap mode not used for blank fuse field");

  chk_fuse_decode: assert property (
    rdy_rise && fuse_used_r && field_r inside {4'h1, 4'h2, 4'h6, 4'h7, 4'h8, 4'h9}
    |-> boot_source_r == field_r && static_width_r == bss_pkg::WIDTH_NONE
  ) else $error("fuse code decoded wrongly");

  chk_fuse_static: assert property (
    rdy_rise && fuse_used_r && field_r inside {4'h3, 4'h4, 4'h5}
    |-> static_width_r == 2'(field_r - 4'h2)
  ) else $error("fuse static width wrong");

  chk_strap_serial: assert property (
    rdy_rise && !fuse_used_r && strap_cap_r inside {4'h0, 4'h1, 4'h8}
    |-> boot_source_r == (strap_cap_r == 4'h0 ? 4'h1 : (strap_cap_r == 4'h1 ? 4'h2 : 4'h9))
  ) else $error("strap serial or quad decode wrong");

  chk_strap_static: assert property (
    rdy_rise && !fuse_used_r && strap_cap_r inside {4'h2, 4'h3, 4'h4}
    |-> boot_source_r == strap_cap_r + 4'h1 && static_width_r == 2'(strap_cap_r - 4'h1)
  ) else $error("strap static decode wrong");

  chk_strap_usb: assert property (
    rdy_rise && !fuse_used_r && strap_cap_r inside {4'h5, 4'h6, 4'h7}
    |-> boot_source_r == strap_cap_r + 4'h1
  ) else $error("strap usb or spi decode wrong");

  chk_pin_function: assert property (
    ready_r |-> pf_ssp_r == (boot_source_r == bss_pkg::SRC_SYNC_SERIAL) &&
                pf_quad_r == (boot_source_r == bss_pkg::SRC_QUAD)
  ) else $error("pin function disagrees with boot source");

  chk_rom_first: assert property (
    state_r == bss_pkg::BSS_ST_START |-> rom_exec_r ##7 ready_r
  ) else $error("selection not done from boot memory in time");

  chk_dev_mode_end: assert property (
    otp.key_set |=> !dev_mode_r && (plain_ok_r == !AES_CAPABLE)
  ) else $error("development mode survives a key");

  chk_secure_boot: assert property (
    otp.key_set |=> cmac_r == AES_CAPABLE && encrypted_r == AES_CAPABLE
  ) else $error("secure boot not enabled with key");

  chk_hold_stable: assert property (
    ready_r && $past(ready_r) |-> $stable(boot_source_r) && $stable(fuse_used_r)
  ) else $error("boot selection changed after decision");

  chk_reserved_flag: assert property (
    rdy_rise && (fuse_used_r ? field_r > 4'h9 : strap_cap_r > 4'h8)
    |-> invalid_r && boot_source_r == bss_pkg::SRC_INVALID
  ) else $error("reserved selection not flagged");

  cov_fuse_boot: cover property (rdy_rise && fuse_used_r);
  cov_strap_boot: cover property (rdy_rise && !fuse_used_r);
  cov_invalid: cover property (rdy_rise && invalid_r);
  cov_key_set: cover property ($rose(otp.key_set));
endmodule

// [testbench/bss_strap_model.sv]
// Board strap model: drives the four strap pins of the selector
`timescale 1ns/10ps
module bss_strap_model (
  input wire logic clk_in,
  input wire logic [3:0] pattern_in,
  input wire logic scramble_in,
  output logic [3:0] strap_out
);
  // ----------------------------------------
  // Strap drive
  // ----------------------------------------
  // Holds the board pattern; when told to, flips every cycle so that
  // a late change on the pins can never pass for the captured value
  initial strap_out = 4'h0;
  always @(posedge clk_in) begin
    if (scramble_in) begin
      strap_out <= ~strap_out;
    end else begin
      strap_out <= pattern_in;
    end
  end
endmodule

// [testbench/bss_top_tb_top.sv]
// Self-checking bench for the boot source selector
`timescale 1ns/10ps
module bss_top_tb_top;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic warm_rst_in = 1'b0;
  logic wr_en = 1'b0;
  logic [3:0] wr_addr = 4'h0;
  logic [31:0] wr_data = 32'h0;
  logic rd_en = 1'b0;
  logic [3:0] rd_addr = 4'h0;
  logic [3:0] pattern = 4'h0;
  logic scramble = 1'b0;
  logic [3:0] strap;
  logic [31:0] rd_data;
  logic rd_valid, from_fuse, invalid, ready, rom_exec, pf_sync, pf_quad;
  logic dev_mode, plain_ok, cmac, enc;
  logic [3:0] source;
  logic [1:0] width;
  int err_count = 0;
  int checks_done = 0;
  int cycle_count = 0;
  logic [31:0] fw;
  logic [31:0] key [4];

  // ----------------------------------------
  // Clock, partner and design
  // ----------------------------------------
  initial forever #50 clk_in = ~clk_in;
  bss_strap_model bss_strap_model_inst (.clk_in(clk_in), .pattern_in(pattern),
    .scramble_in(scramble), .strap_out(strap));
  bss_top #(.AES_CAPABLE(1'b1)) bss_top_inst (.clk_in(clk_in), .rst_in(rst_in),
    .warm_rst_in(warm_rst_in), .strap_pin_3_in(strap[3]), .strap_pin_2_in(strap[2]),
    .strap_pin_1_in(strap[1]), .strap_pin_0_in(strap[0]), .otp_wr_en_in(wr_en),
    .otp_wr_addr_in(wr_addr), .otp_wr_data_in(wr_data), .otp_rd_en_in(rd_en),
    .otp_rd_addr_in(rd_addr), .otp_rd_data_out(rd_data), .otp_rd_valid_out(rd_valid),
    .boot_source_out(source), .static_width_out(width), .boot_from_fuse_out(from_fuse),
    .boot_invalid_out(invalid), .boot_ready_out(ready), .rom_exec_out(rom_exec),
    .pinfunc_sync_serial_out(pf_sync), .pinfunc_quad_out(pf_quad),
    .dev_mode_out(dev_mode), .plain_boot_allowed_out(plain_ok),
    .cmac_auth_out(cmac), .encrypted_boot_out(enc));

  // ----------------------------------------
  // Expectation and report helpers
  // ----------------------------------------
  // Fuse field wins only when marked programmed and nonzero
  function automatic logic [3:0] exp_src(input logic [31:0] w, input logic [3:0] sp);
    if (w[bss_pkg::BOOT_PROG_BIT] && w[3:0] != 4'h0) begin
      return (w[3:0] > 4'h9) ? bss_pkg::SRC_INVALID : w[3:0];
    end
    return (sp > 4'h8) ? bss_pkg::SRC_INVALID : sp + 4'h1;
  endfunction

  function automatic logic [1:0] exp_wid(input logic [3:0] s);
    case (s)
      bss_pkg::SRC_STATIC8: return bss_pkg::WIDTH_8;
      bss_pkg::SRC_STATIC16: return bss_pkg::WIDTH_16;
      bss_pkg::SRC_STATIC32: return bss_pkg::WIDTH_32;
      default: return bss_pkg::WIDTH_NONE;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Cuts a hang short
  always @(posedge clk_in) begin
    cycle_count++;
    if (cycle_count == 20000) begin
      err_count++;
      test_done();
    end
  end

  // ----------------------------------------
  // Fuse store and boot sequence drivers
  // ----------------------------------------
  task automatic otp_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clk_in);
    wr_en <= 1'b0;
  endtask

  task automatic otp_read(input logic [3:0] a, input logic [31:0] e);
    int n;
    @(posedge clk_in);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge clk_in);
    rd_en <= 1'b0;
    n = 0;
    #1;
    while (rd_valid !== 1'b1 && n < 5) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk("otp_rd_valid", 32'h1, {31'h0, rd_valid});
    chk("otp_rd_data", e, rd_data);
    @(posedge clk_in);
    #1;
    chk("otp_rd_valid_pulse", 32'h0, {31'h0, rd_valid});
  endtask

  // Fresh fuses, then the boot word is blown
  task automatic power_on(input logic [31:0] w);
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    if (w !== 32'h0) otp_write(bss_pkg::OTP_IDX_BOOT_CFG, w);
  endtask

  // Warm reset with a strap pattern, then check the decision and its hold
  task automatic boot_case(input logic [31:0] w, input logic [3:0] sp);
    logic [3:0] es;
    int n;
    es = exp_src(w, sp);
    @(posedge clk_in);
    pattern <= sp;
    warm_rst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    #1;
    chk("ready_in_reset", 32'h0, {31'h0, ready});
    @(posedge clk_in);
    warm_rst_in <= 1'b0;
    n = 0;
    #1;
    while (ready !== 1'b1 && n < 12) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk("boot_ready", 32'h1, {31'h0, ready});
    chk("boot_source", {28'h0, es}, {28'h0, source});
    chk("static_width", {30'h0, exp_wid(es)}, {30'h0, width});
    chk("from_fuse", {31'h0, w[31] && w[3:0] != 4'h0}, {31'h0, from_fuse});
    chk("invalid", {31'h0, es == bss_pkg::SRC_INVALID}, {31'h0, invalid});
    chk("pinfunc_sync", {31'h0, es == bss_pkg::SRC_SYNC_SERIAL}, {31'h0, pf_sync});
    chk("pinfunc_quad", {31'h0, es == bss_pkg::SRC_QUAD}, {31'h0, pf_quad});
    chk("rom_exec", 32'h1, {31'h0, rom_exec});
    @(posedge clk_in);
    scramble <= 1'b1;
    repeat (6) @(posedge clk_in);
    scramble <= 1'b0;
    #1;
    chk("source_held", {28'h0, es}, {28'h0, source});
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h9d59));
    repeat (5) @(posedge clk_in);
    #1;
    chk("rst_source", {28'h0, bss_pkg::SRC_INVALID}, {28'h0, source});
    chk("rst_dev_mode", 32'h1, {31'h0, dev_mode});
    chk("rst_cmac", 32'h0, {31'h0, cmac});
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    // Every strap pattern with blank fuses, reserved ones included
    for (int s = 0; s < 16; s++) begin
      boot_case(32'h0, s[3:0]);
    end
    // Every fuse code, zero code falls back to straps
    for (int c = 0; c < 16; c++) begin
      fw = 32'h8000_0000 | c;
      power_on(fw);
      boot_case(fw, 4'($urandom_range(8, 0)));
    end
    // Field set but not marked programmed: straps decide
    power_on(32'h0000_0002);
    boot_case(32'h0000_0002, 4'h8);
    for (int i = 0; i < 6; i++) begin
      fw = $urandom & 32'h8000_000f;
      power_on(fw);
      boot_case(fw, 4'($urandom));
    end
    // General word, boot word and an empty index read back
    // fw still holds the boot word blown by the last power-on
    key[0] = $urandom;
    otp_write(bss_pkg::OTP_IDX_GENERAL, key[0]);
    otp_read(bss_pkg::OTP_IDX_GENERAL, key[0]);
    otp_read(bss_pkg::OTP_IDX_BOOT_CFG, fw);
    otp_read(4'hc, 32'h0);
    chk("dev_before_key", 32'h1, {31'h0, dev_mode});
    chk("plain_before_key", 32'h1, {31'h0, plain_ok});
    chk("cmac_before_key", 32'h0, {31'h0, cmac});
    chk("enc_before_key", 32'h0, {31'h0, enc});
    // Second key block: four words, each one nonzero
    for (int k = 0; k < 4; k++) begin
      key[k] = $urandom | 32'h1;
      otp_write(4'h5 + 4'(k), key[k]);
    end
    for (int k = 0; k < 4; k++) begin
      otp_read(4'h5 + 4'(k), key[k]);
    end
    chk("dev_after_key", 32'h0, {31'h0, dev_mode});
    chk("plain_after_key", 32'h0, {31'h0, plain_ok});
    chk("cmac_after_key", 32'h1, {31'h0, cmac});
    chk("enc_after_key", 32'h1, {31'h0, enc});
    // Warm reset must not bring development mode back
    boot_case(fw, 4'h1);
    chk("dev_after_warm", 32'h0, {31'h0, dev_mode});
    test_done();
  end
endmodule
